// [design/isa_eisa_pkg.sv]
// shared types and constants of the isa/eisa host port
// assumes one 25 mhz clock; every pin is asynchronous to it

package isa_eisa_pkg;

    // ********************************************
    // pin group, sampled through two flip-flops
    // ********************************************
    typedef struct packed {
        logic        eisa;        // mode strap, high for eisa
        logic        rd_n;        // host_read_strobe, active low
        logic        wr_n;        // host_write_strobe, active low
        logic        ads_n;       // address_strobe_in
        logic        cyc_n;       // cycle_strobe_in
        logic        dir;         // direction_in, high on writes
        logic        rdyrtn_n;    // ready_return_in
        logic        local_bus_clock;        // local_bus_clock, sampled level
        logic        dak_n;       // direct_data_select
        logic        exrdy;       // bus ready seen during dma
        logic        aen;         // qualifier, access when low
        logic [3:0]  lanes_n;     // lane selects, active low
        logic [15:1] addr;
        logic [31:0] data;
    } pins_t;

    // ********************************************
    // request to the register core
    // ********************************************
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  offset;
        logic [3:0]  lanes;
        logic [31:0] data;
    } reg_req_t;

    // ********************************************
    // constants
    // ********************************************
    localparam logic [11:0] DECODE_BASE_RST = 12'h030;
    localparam logic [3:0]  ISA_LANES       = 4'h3;
    localparam logic [1:0]  BUF_DEPTH       = 2'h2;
    localparam logic        READY_RST       = 1'h1;
    localparam logic        DECODE_N_RST    = 1'h1;
    localparam logic        STROBE_IDLE     = 1'h1;

    // ********************************************
    // whole state of the port
    // ********************************************
    typedef struct packed {
        pins_t              s1;
        pins_t              s2;
        logic               p_rd_n;
        logic               p_wr_n;
        logic               p_local_bus_clock;
        logic [15:2]        lat_addr;
        logic               lat_aen;
        logic [3:0]         lat_lanes_n;
        logic               rd_pend;
        logic               data_ok;
        logic               ready;
        logic               ldev_n;
        logic [31:0]        dout;
        logic [3:0]         doe;
        reg_req_t           req;
        logic [1:0][31:0]   fifo;
        logic [1:0]         cnt;
        logic               vout;
        logic               overrun;
    } state_t;

endpackage : isa_eisa_pkg

// [design/isa_eisa_host_port.sv]
// isa / eisa host bus slave port: strobes, decode, ready, lanes, dma burst
// assumes pins arrive asynchronously; core answers reads with rd_valid

`timescale 1ns/1ns
`default_nettype none

module isa_eisa_host_port
    import isa_eisa_pkg::*;
#(
    parameter logic [11:0] DECODE_BASE = DECODE_BASE_RST
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire pins_t       pins,
    output logic [31:0]      data_out,
    output logic [3:0]       data_oe,
    output logic             async_ready_out,
    output logic             local_device_decode_n,
    output reg_req_t         reg_req,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_valid,
    output logic [31:0]      dma_word,
    output logic             dma_valid,
    input  wire logic        dma_ready,
    output logic             dma_overrun
);

    // ********************************************
    // helpers
    // ********************************************
    // isa only has two lanes, so upper selects are masked off
    function automatic logic [3:0] lane_mask(input logic eisa, input logic [3:0] l_n);
        lane_mask = eisa ? ~l_n : (~l_n & ISA_LANES);
    endfunction : lane_mask

    function automatic logic [3:0] byte_offset(input logic eisa, input logic [3:1] a);
        byte_offset = eisa ? {a[3:2], 2'h0} : {a[3:1], 1'h0};
    endfunction : byte_offset

    state_t s;
    state_t next_s;

    logic        ads_lo;
    logic [15:1] cur_addr;
    logic        cur_aen;
    logic [3:0]  cur_lanes_n;
    logic [3:0]  mask;
    logic        hit;
    logic        rd_fall;
    logic        wr_rise;
    logic        bclk_rise;
    logic        dma_on;
    logic        push;
    logic        pop;

    // ********************************************
    // decode of the sampled pins
    // ********************************************
    assign ads_lo = !s.s2.ads_n;
    assign cur_addr = {ads_lo ? s.s2.addr[15:2] : s.lat_addr, s.s2.addr[1]};
    assign cur_aen = ads_lo ? s.s2.aen : s.lat_aen;
    assign cur_lanes_n = ads_lo ? s.s2.lanes_n : s.lat_lanes_n;
    assign mask = lane_mask(s.s2.eisa, cur_lanes_n);
    assign hit = (cur_addr[15:4] == DECODE_BASE) && !cur_aen;
    assign rd_fall = s.p_rd_n && !s.s2.rd_n;
    assign wr_rise = !s.p_wr_n && s.s2.wr_n;
    // bus clock edge and dma select
    assign bclk_rise = s.s2.local_bus_clock && !s.p_local_bus_clock;
    assign dma_on = s.s2.eisa && !s.s2.dak_n;
    assign pop = s.vout && dma_ready;
    // no transfer while bus ready is low
    assign push = dma_on && bclk_rise && s.s2.exrdy && s.s2.dir;

    // ********************************************
    // next state
    // ********************************************
    always_comb begin
        next_s = s;
        next_s.s1 = pins;
        next_s.s2 = s.s1;
        next_s.p_rd_n = s.s2.rd_n;
        next_s.p_wr_n = s.s2.wr_n;
        next_s.p_local_bus_clock = s.s2.local_bus_clock;
        next_s.req.valid = 1'h0;
        next_s.overrun = 1'h0;
        // hold address once the strobe rises
        if (ads_lo) begin
            next_s.lat_addr = s.s2.addr[15:2];
            next_s.lat_aen = s.s2.aen;
            next_s.lat_lanes_n = s.s2.lanes_n;
        end
        next_s.ldev_n = !hit;
        // capture data at write trailing edge
        if (wr_rise && hit && !dma_on) begin
            next_s.req.valid = 1'h1;
            next_s.req.write = 1'h1;
            next_s.req.offset = byte_offset(s.s2.eisa, cur_addr[3:1]);
            next_s.req.lanes = mask;
            // isa writes carry only the low word
            // eisa writes keep all 32 bits
            next_s.req.data = s.s2.eisa ? s.s2.data : {16'h0000, s.s2.data[15:0]};
        end
        // reads during a dma burst are not taken
        if (rd_fall && hit && !dma_on) begin
            next_s.req.valid = 1'h1;
            next_s.req.write = 1'h0;
            next_s.req.offset = byte_offset(s.s2.eisa, cur_addr[3:1]);
            next_s.req.lanes = mask;
            next_s.req.data = 32'h0000_0000;
            next_s.rd_pend = 1'h1;
            next_s.data_ok = 1'h0;
            // stall isa read until data arrives
            next_s.ready = s.s2.eisa;
        end
        // ready back at the edge after data
        if (s.rd_pend && rd_valid) begin
            next_s.dout = rd_data;
            next_s.data_ok = 1'h1;
            next_s.rd_pend = 1'h0;
            next_s.ready = 1'h1;
        end
        if (s.s2.rd_n) begin
            next_s.data_ok = 1'h0;
        end
        if (!s.s2.rd_n && hit && s.data_ok && !dma_on) begin
            next_s.doe = mask;
        end else begin
            next_s.doe = 4'h0;
        end
        // the dma source cannot be stalled, so a word meeting a full buffer is dropped
        // two-entry buffer, one word per bus clock
        if (pop) begin
            next_s.fifo[0] = s.fifo[1];
            next_s.cnt = s.cnt - 2'h1;
        end
        if (push) begin
            if (next_s.cnt < BUF_DEPTH) begin
                next_s.fifo[next_s.cnt[0]] = s.s2.data;
                next_s.cnt = next_s.cnt + 2'h1;
            end else begin
                next_s.overrun = 1'h1;
            end
        end
        next_s.vout = (next_s.cnt != 2'h0);
    end

    // ********************************************
    // state register
    // ********************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.ready <= READY_RST;
            s.ldev_n <= DECODE_N_RST;
            // read and write strobes and bus clock reset to their idle level,
            // so no false edge is seen while the sync stages fill
            s.s1.rd_n <= STROBE_IDLE;
            s.s1.wr_n <= STROBE_IDLE;
            s.s1.local_bus_clock <= STROBE_IDLE;
            s.s2.rd_n <= STROBE_IDLE;
            s.s2.wr_n <= STROBE_IDLE;
            s.s2.local_bus_clock <= STROBE_IDLE;
            s.p_rd_n <= STROBE_IDLE;
            s.p_wr_n <= STROBE_IDLE;
            s.p_local_bus_clock <= STROBE_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign data_out = s.dout;
    assign data_oe = s.doe;
    assign async_ready_out = s.ready;
    assign local_device_decode_n = s.ldev_n;
    assign reg_req = s.req;
    assign dma_word = s.fifo[0];
    assign dma_valid = s.vout;
    assign dma_overrun = s.overrun;

    // ********************************************
    // checks
    // ********************************************
    // ready is sampled one cycle after the strobe is seen; the strobe itself
    // passes two sync stages, so slow hosts only
    eisa_ready_a: assert property (@(posedge clk) disable iff (!arst_n)
        s.s2.eisa && $past(s.s2.eisa) |-> async_ready_out)
        else $error("ready dropped in eisa mode");

    isa_lanes_a: assert property (@(posedge clk) disable iff (!arst_n)
        !$past(s.s2.eisa) |-> data_oe[3:2] == 2'h0)
        else $error("upper lanes driven in isa mode");

    decode_out_a: assert property (@(posedge clk) disable iff (!arst_n)
        hit |=> !local_device_decode_n)
        else $error("decode output not active on match");

    lane_float_a: assert property (@(posedge clk) disable iff (!arst_n)
        1'h1 |=> (data_oe & ~$past(mask)) == 4'h0)
        else $error("unselected lane driven");

    write_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
        wr_rise && hit && !dma_on && s.s2.eisa
        |=> reg_req.valid && reg_req.write && reg_req.data == $past(s.s2.data))
        else $error("write data not captured");

    read_stall_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd_fall && hit && !dma_on && !s.s2.eisa |=> !async_ready_out ##0 s.rd_pend)
        else $error("isa read did not stall");

    ready_back_a: assert property (@(posedge clk) disable iff (!arst_n)
        s.rd_pend && rd_valid |=> async_ready_out && data_out == $past(rd_data))
        else $error("ready not restored after data");

    qual_block_a: assert property (@(posedge clk) disable iff (!arst_n)
        cur_aen |=> !reg_req.valid)
        else $error("access taken with qualifier high");

    addr_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s.s2.ads_n) |-> s.lat_addr == $past(s.s2.addr[15:2]) ##1 $stable(s.lat_addr))
        else $error("address not held after strobe rise");

    dma_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !s.s2.exrdy |=> s.cnt <= $past(s.cnt))
        else $error("dma word taken while bus ready low");

    dma_push_a: assert property (@(posedge clk) disable iff (!arst_n)
        push && !pop && s.cnt < BUF_DEPTH |=> s.cnt == $past(s.cnt) + 2'h1)
        else $error("dma word lost");

    // isa and eisa lane patterns, then the remaining checks one by one
    low_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
        !s.s2.eisa && cur_lanes_n[1:0] == 2'h2 |-> mask == 4'h1)
        else $error("low byte pattern picked wrong lanes");
    high_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
        !s.s2.eisa && cur_lanes_n[1:0] == 2'h1 |-> mask == 4'h2)
        else $error("high byte pattern picked wrong lanes");
    eisa_dword_a: assert property (@(posedge clk) disable iff (!arst_n)
        s.s2.eisa && cur_lanes_n == 4'h0 |-> mask == 4'hf)
        else $error("eisa doubleword did not use all lanes");
    isa_upper_a: assert property (@(posedge clk) disable iff (!arst_n)
        wr_rise && hit && !dma_on && !s.s2.eisa |=> reg_req.data[31:16] == 16'h0000)
        else $error("isa write carried upper word");
    addr_miss_a: assert property (@(posedge clk) disable iff (!arst_n)
        cur_addr[15:4] != DECODE_BASE |=> !reg_req.valid)
        else $error("access taken off the decode");
    qual_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s.s2.ads_n) |-> s.lat_aen == $past(s.s2.aen))
        else $error("qualifier not held after strobe rise");
    lane_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s.s2.ads_n) |-> s.lat_lanes_n == $past(s.s2.lanes_n))
        else $error("lane selects not held after strobe rise");
    dma_path_a: assert property (@(posedge clk) disable iff (!arst_n)
        dma_on |=> !reg_req.valid)
        else $error("register access taken during dma");
    decode_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
        !hit |=> local_device_decode_n)
        else $error("decode output active without match");
    oe_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        s.s2.rd_n |=> data_oe == 4'h0)
        else $error("lanes driven with read strobe idle");
    write_ready_a: assert property (@(posedge clk) disable iff (!arst_n)
        wr_rise && hit && !dma_on && !s.rd_pend && !rd_fall |=> async_ready_out)
        else $error("write stalled the bus");
    overrun_a: assert property (@(posedge clk) disable iff (!arst_n)
        push && !pop && s.cnt == BUF_DEPTH |=> dma_overrun)
        else $error("dropped dma word not flagged");

    // ********************************************
    // coverage
    // ********************************************

    read_cov: cover property (@(posedge clk) disable iff (!arst_n)
        rd_fall && hit ##[1:20] data_oe != 4'h0);
    write_cov: cover property (@(posedge clk) disable iff (!arst_n)
        reg_req.valid && reg_req.write);
    burst_cov: cover property (@(posedge clk) disable iff (!arst_n)
        push ##[3:8] push ##[3:8] push);
    full_cov: cover property (@(posedge clk) disable iff (!arst_n)
        s.cnt == BUF_DEPTH && !dma_ready);
    overrun_cov: cover property (@(posedge clk) disable iff (!arst_n)
        dma_overrun);

endmodule : isa_eisa_host_port

`default_nettype wire

// [verification/isa_host_model.sv]
// host bus model: isa/eisa i/o strobes and eisa slave dma bursts
// assumes the bench calls its tasks; pins change only at falling clk
`timescale 1ns/1ns
`default_nettype none
module isa_host_model
    import isa_eisa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [31:0] data_out,
    input  wire logic [3:0]  data_oe,
    output pins_t            pins,
    output logic [31:0]      bus
);
    // ********
    // bus cycles
    // ********
    // unused inputs held
    initial begin
        pins = '1;
        pins.eisa = 1'h0;
        pins.ads_n = 1'h0;
    end
    // released lanes show the inverse, so a float never passes for data
    always_comb
        for (int i = 0; i < 4; i++)
            bus[8*i+:8] = data_oe[i] ? data_out[8*i+:8] : ~pins.data[8*i+:8];
    task automatic access(input logic em, input logic wr, input logic q,
                          input logic [15:1] a, input logic [3:0] ln, input logic [31:0] d,
                          output logic [31:0] rd, output logic [3:0] oe);
        @(negedge clk);
        pins.eisa = em;
        pins.ads_n = 1'h0;
        pins.addr = a;
        pins.lanes_n = ln;
        pins.aen = q;
        pins.data = d;
        // address phase, then pins go stale
        if (em) begin
            repeat (4) @(negedge clk);
            pins.ads_n = 1'h1;
            repeat (2) @(negedge clk);
            pins.addr = ~a;
            pins.lanes_n = 4'h0;
            pins.aen = 1'h1;
        end
        repeat (3) @(negedge clk);
        pins.rd_n = wr;
        pins.wr_n = ~wr;
        repeat (16) @(negedge clk);
        rd = bus;
        oe = data_oe;
        pins.rd_n = 1'h1;
        pins.wr_n = 1'h1;
        repeat (4) @(negedge clk);
        pins.data = ~d;
        pins.aen = 1'h1;
    endtask : access
    task automatic burst(input logic [31:0] d0, input int n, input int skip);
        @(negedge clk);
        pins.eisa = 1'h1;
        pins.ads_n = 1'h1;
        pins.rd_n = 1'h1;
        pins.dak_n = 1'h0;
        pins.dir = 1'h1;
        for (int i = 0; i < n; i++) begin
            pins.data = d0 + 32'(i);
            pins.exrdy = (i != skip);
            pins.local_bus_clock = 1'h0;
            repeat (2) @(negedge clk);
            pins.local_bus_clock = 1'h1;
            repeat (3) @(negedge clk);
        end
        pins.dak_n = 1'h1;
        pins.exrdy = 1'h1;
        pins.data = ~pins.data;
    endtask : burst
endmodule : isa_host_model
`default_nettype wire

// [verification/isa_eisa_host_port_tb.sv]
// self-checking bench of the isa/eisa host port
// assumes the host model drives every pin; the bench plays the core
`timescale 1ns/1ns
`default_nettype none
module isa_eisa_host_port_tb
    import isa_eisa_pkg::*;
;
    // ********
    // harness
    // ********
    logic        clk, arst_n, rd_valid, dma_ready, dma_valid, dma_overrun;
    logic        async_ready_out, local_device_decode_n, ready_low, dec_low;
    logic [31:0] data_out, rd_data, dma_word, bus, rd;
    logic [31:0] popped[$];
    logic [3:0]  data_oe, oe;
    pins_t       pins;
    reg_req_t    reg_req, last_req;
    int          n_fail, checked, n_req, n_ovr, wait_n, cycles, n0;
    isa_eisa_host_port i_dut (.clk(clk), .arst_n(arst_n), .pins(pins), .data_out(data_out),
        .data_oe(data_oe), .async_ready_out(async_ready_out), .reg_req(reg_req),
        .local_device_decode_n(local_device_decode_n), .rd_data(rd_data), .rd_valid(rd_valid),
        .dma_word(dma_word), .dma_valid(dma_valid), .dma_ready(dma_ready),
        .dma_overrun(dma_overrun));
    isa_host_model i_host (.clk(clk), .data_out(data_out), .data_oe(data_oe), .pins(pins),
        .bus(bus));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // the ceiling sits well above the few hundred cycles the tests take
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (reg_req.valid === 1'h1) begin
            last_req <= reg_req;
            n_req <= n_req + 1;
            if (!reg_req.write) wait_n <= 4;
        end
        if (dma_valid && dma_ready) popped.push_back(dma_word);
        if (dma_overrun === 1'h1) n_ovr <= n_ovr + 1;
        if (async_ready_out === 1'h0) ready_low <= 1'h1;
        if (local_device_decode_n === 1'h0) dec_low <= 1'h1;
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end
    // core answers a read four cycles late, so isa reads must stall
    always @(negedge clk) begin
        rd_valid = 1'h0;
        if (wait_n == 1) begin
            if (!pins.eisa) check({31'h0, async_ready_out}, 32'h0);
            rd_valid = 1'h1;
        end
        if (wait_n > 0) wait_n = wait_n - 1;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run();
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    function automatic logic [31:0] bytes(input logic [3:0] m);
        return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction : bytes
    // ********
    // scenarios
    // ********
    task automatic t_reset();
        check({23'h0, data_oe, async_ready_out, local_device_decode_n, reg_req.valid,
               dma_valid, dma_overrun}, 32'h18);
        check(data_out, 32'h0);
    endtask : t_reset
    task automatic t_isa_write();
        for (int k = 0; k < 3; k++) begin
            n0 = n_req;
            i_host.access(1'h0, 1'h1, 1'h0, {DECODE_BASE_RST, 3'(k + 1)}, {2'h3, 2'(k)},
                          32'h5a5a_c3c3 ^ 32'(k), rd, oe);
            check(32'(n_req - n0), 32'h1);
            check({23'h0, last_req.write, last_req.lanes, last_req.offset},
                  {23'h0, 1'h1, 2'h0, ~2'(k), 3'(k + 1), 1'h0});
            check(last_req.data, {16'h0, 16'hc3c3 ^ 16'(k)});
        end
        check({31'h0, dec_low}, 32'h1);
    endtask : t_isa_write
    // isa reads stall and drive chosen lanes only
    task automatic t_isa_read();
        for (int k = 0; k < 3; k++) begin
            ready_low = 1'h0;
            i_host.access(1'h0, 1'h0, 1'h0, {DECODE_BASE_RST, 3'h2}, {2'h3, 2'(k)}, 32'h0, rd, oe);
            check({28'h0, oe}, {30'h0, ~2'(k)});
            check(rd & bytes(oe), rd_data & bytes({2'h0, ~2'(k)}));
            check({30'h0, ready_low, async_ready_out}, 32'h3);
        end
    endtask : t_isa_read
    // nothing off the decode or with the qualifier high
    task automatic t_miss();
        // let the decode output settle after the last read
        repeat (4) @(negedge clk);
        n0 = n_req;
        dec_low = 1'h0;
        i_host.access(1'h0, 1'h1, 1'h0, {~DECODE_BASE_RST, 3'h0}, 4'hc, 32'h1, rd, oe);
        i_host.access(1'h0, 1'h1, 1'h1, {DECODE_BASE_RST, 3'h0}, 4'hc, 32'h1, rd, oe);
        check(32'(n_req - n0), 32'h0);
        check({31'h0, dec_low}, 32'h0);
    endtask : t_miss
    // eisa decodes from latched address phase
    task automatic t_eisa();
        n0 = n_req;
        ready_low = 1'h0;
        i_host.access(1'h1, 1'h1, 1'h0, {DECODE_BASE_RST, 3'h6}, 4'h3, 32'hc0de_1234, rd, oe);
        check(32'(n_req - n0), 32'h1);
        check({23'h0, last_req.write, last_req.lanes, last_req.offset}, 32'h1cc);
        check(last_req.data, 32'hc0de_1234);
        i_host.access(1'h1, 1'h0, 1'h0, {DECODE_BASE_RST, 3'h6}, 4'h3, 32'h0, rd, oe);
        check({28'h0, oe}, 32'hc);
        check(rd & 32'hffff_0000, rd_data & 32'hffff_0000);
        check({31'h0, ready_low}, 32'h0);
    endtask : t_eisa
    // bursts into a stalled buffer, then a wait state
    task automatic t_dma();
        logic [31:0] exp[5] = '{32'h1000_0000, 32'h1000_0001, 32'h2000_0000,
                                32'h2000_0002, 32'h2000_0003};
        popped.delete();
        n0 = n_ovr;
        i_host.burst(32'h1000_0000, 3, -1);
        repeat (4) @(negedge clk);
        check({31'h0, dma_valid}, 32'h1);
        check(32'(n_ovr - n0), 32'h1);
        dma_ready = 1'h1;
        repeat (4) @(negedge clk);
        i_host.burst(32'h2000_0000, 4, 1);
        repeat (6) @(negedge clk);
        check(32'(popped.size()), 32'h5);
        for (int i = 0; i < 5; i++) check(popped[i], exp[i]);
    endtask : t_dma
    initial begin
        {arst_n, rd_valid, dma_ready, ready_low, dec_low} = 5'h0;
        {n_fail, checked, n_req, n_ovr, wait_n, cycles, n0} = '0;
        rd_data = 32'h3c5a_a5c3;
        repeat (4) @(posedge clk);
        @(negedge clk);
        t_reset();
        arst_n = 1'h1;
        repeat (4) @(negedge clk);
        t_reset();
        t_isa_write();
        t_isa_read();
        t_miss();
        t_eisa();
        t_dma();
        complete_run();
    end
endmodule : isa_eisa_host_port_tb
`default_nettype wire
